// *** src/spmp_pkg.sv ***
// Purpose: constants shared by the serial port block
// Assumes: 250 MHz system clock
// Notes:   register offsets are word indices on a plain register port
package spmp_pkg;

  // register offsets
  localparam logic [2:0] OFS_CONTROL  = 3'h0;
  localparam logic [2:0] OFS_FLAGS    = 3'h1;
  localparam logic [2:0] OFS_DATA     = 3'h2;
  localparam logic [2:0] OFS_DIR      = 3'h3;
  localparam logic [2:0] OFS_PORT_OUT = 3'h4;

  // control fields
  localparam int CTL_IE   = 7;
  localparam int CTL_PE   = 6;
  localparam int CTL_WOM  = 5;
  localparam int CTL_MS   = 4;
  localparam int CTL_POL  = 3;
  localparam int CTL_PHA  = 2;
  localparam int CTL_RHI  = 1;
  localparam int CTL_RLO  = 0;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // flag fields
  localparam int FLG_DONE = 7;
  localparam int FLG_WRITE_COLLISION_FLAG = 6;
  localparam int FLG_MODE_FAULT_FLAG = 4;

  // port d bits used by the serial port
  localparam int PD_SS   = 5;
  localparam int PD_SCK  = 4;
  localparam int PD_MOSI = 3;
  localparam int PD_MISO = 2;
  localparam logic [7:0] DIR_RST  = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hff;

  // bit periods and half-period counts
  localparam int CLK_MHZ      = 250;
  localparam int PER_NS_2M    = 500;
  localparam int PER_NS_1M    = 1000;
  localparam int PER_NS_250K  = 4000;
  localparam int PER_NS_125K  = 8000;
  localparam logic [9:0] HALF_2M   = 10'(PER_NS_2M * CLK_MHZ / 2000);
  localparam logic [9:0] HALF_1M   = 10'(PER_NS_1M * CLK_MHZ / 2000);
  localparam logic [9:0] HALF_250K = 10'(PER_NS_250K * CLK_MHZ / 2000);
  localparam logic [9:0] HALF_125K = 10'(PER_NS_125K * CLK_MHZ / 2000);

  localparam logic [3:0] LAST_EDGE = 4'hf;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } spmp_state_e;

endpackage

// *** src/spmp_port.sv ***
// Purpose: serial peripheral port, master or slave, one byte per exchange
// Assumes: link pins arrive unsynchronised; register port on clk
// Notes:   slave edges are found by oversampling the link clock
//
// Function
// - only the master starts a full-duplex byte exchange
// - master drives mosi, slave drives miso
// - master data write starts clock and shift
// - exchange end sets done flag, interrupt
// - interrupt enable gates done, collision, fault
// - master select picks role; slave forces ss input
// - master: ss direction bit picks gpio or input
// - master with ss input low: mode fault
// - wired-or mode: outputs never drive high
// - polarity sets idle level and leading edge
// - phase picks leading or trailing valid edge
// - data changes half period before valid edge
// - phase 0 needs ss toggle between bytes
// - two low control bits set master rate
// - master drives clock and selects via ss
// - dummy write clocks in receive-only data
// - unselected slave ignores clock, floats miso
// - flags read then data access clears done
// - data write while busy flags collision
// - mode fault clears directions, master, enable
`timescale 1ns/1ps
`default_nettype none

module spmp_port (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rd_data,
  output logic            irq,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe,
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe,
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe,
  input  wire logic       ss_n_i,
  output logic            ss_n_o,
  output logic            ss_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage a is read only by stage b
  logic [3:0] sync_a_r;
  logic [3:0] sync_b_r;
  logic       sck_prev_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_a_r   <= 4'h1; // select starts at its idle high level
      sync_b_r   <= 4'h1;
      sck_prev_r <= 1'b0;
    end else begin
      sync_a_r   <= {sck_i, mosi_i, miso_i, ss_n_i};
      sync_b_r   <= sync_a_r;
      sck_prev_r <= sync_b_r[3];
    end
  end

  logic sck_s, mosi_s, miso_s, ss_s;
  assign {sck_s, mosi_s, miso_s, ss_s} = sync_b_r;

  ////////////////////////////////////////////////////////////////////////////
  // state
  spmp_pkg::spmp_state_e state_r, state_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] flg_r, flg_nxt;
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] pout_r, pout_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] rbuf_r, rbuf_nxt;
  logic [9:0] div_r, div_nxt;
  logic [3:0] edge_r, edge_nxt;
  logic       msck_r, msck_nxt;
  logic [2:0] armed_r, armed_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic       irq_r, irq_nxt;

  logic       pe, ms, pol, pha, wom;
  logic [9:0] half;
  logic       wr_ctl, wr_dat, rd_dat, rd_flg;
  logic       tick, edge_evt, lead, sample, shift, done, busy, mode_fault_flag_evt;

  assign pe  = ctl_r[spmp_pkg::CTL_PE];
  assign ms  = ctl_r[spmp_pkg::CTL_MS];
  assign pol = ctl_r[spmp_pkg::CTL_POL];
  assign pha = ctl_r[spmp_pkg::CTL_PHA];
  assign wom = ctl_r[spmp_pkg::CTL_WOM];

  assign wr_ctl = wr_stb && addr == spmp_pkg::OFS_CONTROL;
  assign wr_dat = wr_stb && addr == spmp_pkg::OFS_DATA;
  assign rd_dat = rd_stb && addr == spmp_pkg::OFS_DATA;
  assign rd_flg = rd_stb && addr == spmp_pkg::OFS_FLAGS;

  always_comb begin
    case ({ctl_r[spmp_pkg::CTL_RHI], ctl_r[spmp_pkg::CTL_RLO]})
      2'b00:   half = spmp_pkg::HALF_2M;
      2'b01:   half = spmp_pkg::HALF_1M;
      2'b10:   half = spmp_pkg::HALF_250K;
      default: half = spmp_pkg::HALF_125K;
    endcase
  end

  // master edges come from the divider, slave edges from the sampled pin
  assign tick = ms && state_r == spmp_pkg::ST_RUN && div_r == half - 10'h001;
  always_comb begin
    if (ms) begin
      edge_evt = tick;
      lead     = !edge_r[0];
    end else begin
      edge_evt = pe && !ss_s && (sck_s != sck_prev_r);
      lead     = (sck_prev_r == pol);
    end
  end
  assign sample = edge_evt && (lead != pha);
  assign shift  = edge_evt && (lead == pha) && !(pha && edge_r == 4'h0);
  assign done   = edge_evt && edge_r == spmp_pkg::LAST_EDGE;
  assign busy   = ms ? (state_r == spmp_pkg::ST_RUN) : (edge_r != 4'h0);
  assign mode_fault_flag_evt = pe && ms && !dir_r[spmp_pkg::PD_SS] && !ss_s;

  ////////////////////////////////////////////////////////////////////////////
  // next values
  always_comb begin
    state_nxt = state_r;
    ctl_nxt   = ctl_r;
    flg_nxt   = flg_r;
    dir_nxt   = dir_r;
    pout_nxt  = pout_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    rbuf_nxt  = rbuf_r;
    div_nxt   = div_r;
    edge_nxt  = edge_r;
    msck_nxt  = msck_r;
    armed_nxt = armed_r;
    rd_nxt    = 8'h00;

    if (wr_stb && addr == spmp_pkg::OFS_DIR)      dir_nxt  = wr_data;
    if (wr_stb && addr == spmp_pkg::OFS_PORT_OUT) pout_nxt = wr_data;
    if (wr_ctl) ctl_nxt = wr_data;

    // flag clears need a flags read first; a new event wins below
    if (rd_flg) armed_nxt = {flg_r[spmp_pkg::FLG_DONE], flg_r[spmp_pkg::FLG_WRITE_COLLISION_FLAG],
                             flg_r[spmp_pkg::FLG_MODE_FAULT_FLAG]};
    if ((rd_dat || wr_dat) && armed_r[2]) flg_nxt[spmp_pkg::FLG_DONE] = 1'b0;
    if ((rd_dat || wr_dat) && armed_r[1]) flg_nxt[spmp_pkg::FLG_WRITE_COLLISION_FLAG] = 1'b0;
    if (wr_ctl && armed_r[0]) flg_nxt[spmp_pkg::FLG_MODE_FAULT_FLAG] = 1'b0;
    if (rd_dat || wr_dat) armed_nxt[2:1] = 2'b00;
    if (wr_ctl) armed_nxt[0] = 1'b0;

    if (wr_dat && busy) flg_nxt[spmp_pkg::FLG_WRITE_COLLISION_FLAG] = 1'b1;
    else if (wr_dat) tx_nxt = wr_data;

    if (!pe || (!ms && ss_s && !pha)) edge_nxt = 4'h0;

    if (ms && pe && state_r == spmp_pkg::ST_IDLE && wr_dat) begin
      state_nxt = spmp_pkg::ST_RUN;
      div_nxt   = 10'h000;
      edge_nxt  = 4'h0;
      msck_nxt  = pol;
    end
    if (state_r == spmp_pkg::ST_RUN) begin
      div_nxt = tick ? 10'h000 : div_r + 10'h001;
      if (tick) msck_nxt = !msck_r;
    end

    if (edge_evt && pe) begin
      edge_nxt = edge_r + 4'h1;
      if (sample) rx_nxt = {rx_r[6:0], ms ? miso_s : mosi_s};
      if (shift)  tx_nxt = {tx_r[6:0], 1'b0};
    end
    if (done && pe) begin
      flg_nxt[spmp_pkg::FLG_DONE] = 1'b1;
      rbuf_nxt  = sample ? {rx_r[6:0], ms ? miso_s : mosi_s} : rx_r;
      state_nxt = spmp_pkg::ST_IDLE;
      edge_nxt  = 4'h0;
      msck_nxt  = pol;
    end

    if (mode_fault_flag_evt) begin
      flg_nxt[spmp_pkg::FLG_MODE_FAULT_FLAG] = 1'b1;
      dir_nxt   = 8'h00;
      ctl_nxt[spmp_pkg::CTL_MS] = 1'b0;
      ctl_nxt[spmp_pkg::CTL_PE] = 1'b0;
      state_nxt = spmp_pkg::ST_IDLE;
      edge_nxt  = 4'h0;
      msck_nxt  = pol;
    end
    if (!pe || !ms) state_nxt = spmp_pkg::ST_IDLE;
    if (state_nxt == spmp_pkg::ST_IDLE) msck_nxt = ctl_nxt[spmp_pkg::CTL_POL];

    if (rd_stb) begin
      case (addr)
        spmp_pkg::OFS_CONTROL:  rd_nxt = ctl_r;
        spmp_pkg::OFS_FLAGS:    rd_nxt = flg_r;
        spmp_pkg::OFS_DATA:     rd_nxt = rbuf_r;
        spmp_pkg::OFS_DIR:      rd_nxt = dir_r;
        spmp_pkg::OFS_PORT_OUT: rd_nxt = pout_r;
        default:                rd_nxt = 8'h00;
      endcase
    end
    irq_nxt = ctl_nxt[spmp_pkg::CTL_IE] && (flg_nxt[spmp_pkg::FLG_DONE] ||
              flg_nxt[spmp_pkg::FLG_WRITE_COLLISION_FLAG] || flg_nxt[spmp_pkg::FLG_MODE_FAULT_FLAG]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= spmp_pkg::ST_IDLE;
      ctl_r   <= spmp_pkg::CONTROL_RST;
      flg_r   <= 8'h00;
      dir_r   <= spmp_pkg::DIR_RST;
      pout_r  <= spmp_pkg::PORT_RST;
      tx_r    <= 8'h00;
      rx_r    <= 8'h00;
      rbuf_r  <= 8'h00;
      div_r   <= 10'h000;
      edge_r  <= 4'h0;
      msck_r  <= 1'b0;
      armed_r <= 3'h0;
      rd_r    <= 8'h00;
      irq_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctl_r   <= ctl_nxt;
      flg_r   <= flg_nxt;
      dir_r   <= dir_nxt;
      pout_r  <= pout_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      rbuf_r  <= rbuf_nxt;
      div_r   <= div_nxt;
      edge_r  <= edge_nxt;
      msck_r  <= msck_nxt;
      armed_r <= armed_nxt;
      rd_r    <= rd_nxt;
      irq_r   <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins; wired-or mode only ever pulls low, pull-ups must be fitted
  function automatic logic drive(input logic en, input logic val, input logic w);
    drive = en && !(w && val);
  endfunction

  assign rd_data = rd_r;
  assign irq     = irq_r;
  assign sck_o   = msck_r;
  assign mosi_o  = tx_r[7];
  assign miso_o  = tx_r[7];
  assign ss_n_o  = pout_r[spmp_pkg::PD_SS];
  assign sck_oe  = drive(pe && ms && dir_r[spmp_pkg::PD_SCK], msck_r, wom);
  assign mosi_oe = drive(pe && ms && dir_r[spmp_pkg::PD_MOSI], tx_r[7], wom);
  assign miso_oe = drive(pe && !ms && !ss_s && dir_r[spmp_pkg::PD_MISO], tx_r[7], wom);
  assign ss_n_oe = drive(ms && dir_r[spmp_pkg::PD_SS], pout_r[spmp_pkg::PD_SS], wom);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_idle_level;
    ms && state_r == spmp_pkg::ST_IDLE |-> msck_r == pol;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not idle");

  property p_start;
    ms && pe && state_r == spmp_pkg::ST_IDLE && wr_dat && !mode_fault_flag_evt |=> state_r == spmp_pkg::ST_RUN;
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_done_flag;
    done && pe |=> flg_r[spmp_pkg::FLG_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag missing");

  property p_irq;
    flg_r[spmp_pkg::FLG_DONE] && ctl_r[spmp_pkg::CTL_IE] && !rd_dat && !wr_dat && !wr_ctl
      |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_write_collision_flag;
    wr_dat && busy |=> flg_r[spmp_pkg::FLG_WRITE_COLLISION_FLAG] && ($stable(tx_r) || $past(edge_evt));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_mode_fault_flag;
    mode_fault_flag_evt |=> !ms && !pe && dir_r == 8'h00 && flg_r[spmp_pkg::FLG_MODE_FAULT_FLAG];
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("fault not handled");

  property p_unselected;
    !ms && ss_s |-> !miso_oe;
  endproperty
  a_unselected: assert property (p_unselected) else $error("miso driven");

  property p_clear_done;
    armed_r[2] && rd_dat && !done |=> !flg_r[spmp_pkg::FLG_DONE];
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("done not cleared");

  property p_rate;
    tick |-> div_r == half - 10'h001 && $past(div_r) == half - 10'h002;
  endproperty
  a_rate: assert property (p_rate) else $error("bad half period");

endmodule

`default_nettype wire

// *** verif/spmp_far_end.sv ***
// Purpose: behavioural far-end peripheral for the serial port bench
// Assumes: pol/pha set by the bench to match the port's control byte
// Notes:   miso shows the inverse of its last value when deselected
`timescale 1ns/1ps
`default_nettype none
module spmp_far_end (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx
);
  logic [7:0] sh;
  logic       first;
  initial miso = 1'b0;
  // a fresh byte is loaded on every select
  always @(negedge ss_n) begin
    sh = tx;
    first = 1'b1;
  end
  always @(sck) begin
    if (!ss_n) begin
      if (sck == (pol == pha)) rx = {rx[6:0], mosi};
      else if (pha && first) first = 1'b0;
      else sh = {sh[6:0], 1'b0};
    end
  end
  always @(ss_n or sh) begin
    if (!ss_n) miso = sh[7];
    else miso = ~miso;
  end
endmodule
`default_nettype wire

// *** verif/spmp_port_bench.sv ***
// Purpose: self-checking bench for the serial port block
// Assumes: far end modelled by spmp_far_end
// Notes:   select is pulled up when nobody drives it
`timescale 1ns/1ps
`default_nettype none
module spmp_port_bench;
  typedef struct packed {logic [7:0] c; logic [7:0] t; logic [7:0] s; int h;} spmp_row_s;
  logic       clk, nrst, wr_stb, rd_stb, irq, sck_o, sck_oe, mosi_o, mosi_oe;
  logic       miso_o, miso_oe, ss_n_o, ss_n_oe, sck_d, mosi_d, ss_d, far_miso, pol, pha;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, far_tx, far_rx, v, got;
  int         n, edges, error_cnt, n_checks;
  wire sck_w  = sck_oe ? sck_o : sck_d;
  wire mosi_w = mosi_oe ? mosi_o : mosi_d;
  wire miso_w = miso_oe ? miso_o : far_miso;
  wire ss_w   = ss_n_oe ? ss_n_o : ss_d;
  spmp_row_s rows [4] = '{'{8'hd0, 8'ha5, 8'h3c, 62}, '{8'hd5, 8'h81, 8'h7e, 125},
                          '{8'hda, 8'h01, 8'hfe, 500}, '{8'hdf, 8'hc3, 8'h5a, 1000}};
  spmp_port i_spmp_port (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
    .ss_n_oe(ss_n_oe));
  spmp_far_end i_spmp_far_end (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .pol(pol),
    .pha(pha), .tx(far_tx), .miso(far_miso), .rx(far_rx));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(sck_w) edges++;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    while (irq !== 1'b1 && k < 20000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 20000) begin
      error_cnt++;
      $display("wrong value at %0t: interrupt timeout", $time);
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, wr_stb, rd_stb, addr, wr_data, sck_d, mosi_d, pol, pha, far_tx} = '0;
    ss_d = 1'b1;
    tick(2);
    nrst <= 1'b1;
    rd(spmp_pkg::OFS_CONTROL, v);
    chk(v, spmp_pkg::CONTROL_RST);
    rd(spmp_pkg::OFS_PORT_OUT, v);
    chk(v, spmp_pkg::PORT_RST);
    rd(3'h7, v);
    chk(v, 8'h00);
    wr(spmp_pkg::OFS_DIR, 8'h38);
    foreach (rows[i]) begin
      pol <= rows[i].c[3];
      pha <= rows[i].c[2];
      far_tx <= rows[i].s;
      wr(spmp_pkg::OFS_CONTROL, rows[i].c & 8'hbf);
      wr(spmp_pkg::OFS_CONTROL, rows[i].c);
      wr(spmp_pkg::OFS_PORT_OUT, 8'hdf);
      tick(2);
      chk(sck_w, rows[i].c[3]);
      chk(ss_w, 1'b0);
      edges = 0;
      wr(spmp_pkg::OFS_DATA, rows[i].t);
      wait_irq(n);
      chk(n >= 16 * rows[i].h - 2 && n <= 16 * rows[i].h + 6, 8'h01);
      chk(8'(edges), 8'd16);
      rd(spmp_pkg::OFS_FLAGS, v);
      chk(v & 8'hd0, 8'h80);
      rd(spmp_pkg::OFS_DATA, v);
      chk(v, rows[i].s);
      chk(far_rx, rows[i].t);
      tick(2);
      chk(irq, 1'b0);
      wr(spmp_pkg::OFS_PORT_OUT, 8'hff);
      $display("row %0d done", i);
    end
    // collision with interrupts off, then enabling shows the pending request
    {pol, pha} <= 2'b00;
    far_tx <= 8'h69;
    wr(spmp_pkg::OFS_CONTROL, 8'h50);
    wr(spmp_pkg::OFS_PORT_OUT, 8'hdf);
    wr(spmp_pkg::OFS_DATA, 8'h96);
    wr(spmp_pkg::OFS_DATA, 8'h11);
    tick(1100);
    chk(irq, 1'b0);
    wr(spmp_pkg::OFS_CONTROL, 8'hd0);
    tick(2);
    chk(irq, 1'b1);
    rd(spmp_pkg::OFS_FLAGS, v);
    chk(v & 8'hd0, 8'hc0);
    rd(spmp_pkg::OFS_DATA, v);
    chk(v, 8'h69);
    chk(far_rx, 8'h96);
    rd(spmp_pkg::OFS_FLAGS, v);
    chk(v & 8'hd0, 8'h00);
    wr(spmp_pkg::OFS_PORT_OUT, 8'hff);
    $display("collision done");
    wr(spmp_pkg::OFS_CONTROL, 8'h78);
    tick(2);
    chk(sck_oe, 1'b0);
    chk(ss_n_oe, 1'b0);
    wr(spmp_pkg::OFS_DIR, 8'h18);
    wr(spmp_pkg::OFS_CONTROL, 8'hd0);
    ss_d <= 1'b0;
    tick(6);
    chk(irq, 1'b1);
    rd(spmp_pkg::OFS_FLAGS, v);
    chk(v & 8'hd0, 8'h10);
    rd(spmp_pkg::OFS_CONTROL, v);
    chk(v & 8'h50, 8'h00);
    rd(spmp_pkg::OFS_DIR, v);
    chk(v, 8'h00);
    ss_d <= 1'b1;
    $display("mode fault done");
    // slave role, bench drives the link clock at about 125 ns
    wr(spmp_pkg::OFS_CONTROL, 8'h40);
    wr(spmp_pkg::OFS_DIR, 8'h04);
    wr(spmp_pkg::OFS_DATA, 8'ha5);
    tick(4);
    chk(miso_oe, 1'b0);
    ss_d <= 1'b0;
    tick(6);
    chk(miso_oe, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      mosi_d <= 8'h3c >> i;
      tick(15);
      got[i] = miso_w;
      sck_d <= 1'b1;
      tick(16);
      sck_d <= 1'b0;
    end
    tick(40);
    chk(got, 8'ha5);
    rd(spmp_pkg::OFS_FLAGS, v);
    chk(v & 8'h80, 8'h80);
    rd(spmp_pkg::OFS_DATA, v);
    chk(v, 8'h3c);
    ss_d <= 1'b1;
    $display("slave done");
    close_out();
  end
endmodule
`default_nettype wire
